// *** alo_serial_lane_out.sv ***
// Quad-channel serial lane output: latency, formatting and lane serializers
`include "alo_defs.svh"
`default_nettype none
module alo_serial_lane_out #(
    parameter int BIT_DIV = `ALO_BIT_DIV,
    parameter int LAT = `ALO_LAT_SAMPLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_sample_clk,
    input wire logic [3:0][13:0] i_ch_data,
    input wire logic [3:0] i_ovr_pos,
    input wire logic [3:0] i_ovr_neg,
    input wire alo_pkg::alo_cfg_t i_pin_cfg,
    input wire alo_pkg::alo_cfg_t i_serial_cfg,
    input wire logic i_cfg_from_serial,
    output logic o_bit_clk,
    output logic o_frame_clk,
    output logic o_ch_a_lane0,
    output logic o_ch_a_lane1,
    output logic o_ch_b_lane0,
    output logic o_ch_b_lane1,
    output logic o_ch_c_lane0,
    output logic o_ch_c_lane1,
    output logic o_ch_d_lane0,
    output logic o_ch_d_lane1,
    output logic [1:0] o_lane_drive_current_select,
    output logic o_lane_drive_current_doubling,
    output logic [4:0] o_term_clk_sel,
    output logic [4:0] o_term_data_sel
);
    localparam int CH = 4;
    localparam int MW = CH * 16;
    localparam int AW = (LAT > 1) ? $clog2(LAT) : 1;
    localparam int DVW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

    // ==========================================================
    // Helpers
    function automatic logic [7:0] evens(input logic [15:0] w);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = w[2 * i];
        end
        return r;
    endfunction

    function automatic logic [7:0] odds(input logic [15:0] w);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = w[2 * i + 1];
        end
        return r;
    endfunction

    // Left-aligns len bits of v; LSB first puts v[0] on top
    function automatic logic [15:0] place(input logic [15:0] v, input logic [4:0] len, input logic lsb);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[15 - i] = v[i];
        end
        if (!lsb) begin
            r = v << (5'd16 - len);
        end
        return r;
    endfunction

    // ==========================================================
    // Input synchronisers
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic [MW-1:0] din_s1_reg, din_s2_reg;
    logic sel_s1_reg, sel_s2_reg;
    alo_pkg::alo_cfg_t pcfg_s1_reg, pcfg_s2_reg, scfg_s1_reg, scfg_s2_reg;
    wire logic [MW-1:0] din_raw;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            din_s1_reg <= '0;
            din_s2_reg <= '0;
        end else begin
            sclk_s1_reg <= i_sample_clk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            din_s1_reg <= din_raw;
            din_s2_reg <= din_s1_reg;
        end
    end

    // Reset state: MSB first, two's complement, 3.5 mA, no termination
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_s1_reg <= 1'b0;
            sel_s2_reg <= 1'b0;
            pcfg_s1_reg <= '0;
            pcfg_s2_reg <= '0;
            scfg_s1_reg <= '0;
            scfg_s2_reg <= '0;
        end else begin
            sel_s1_reg <= i_cfg_from_serial;
            sel_s2_reg <= sel_s1_reg;
            pcfg_s1_reg <= i_pin_cfg;
            pcfg_s2_reg <= pcfg_s1_reg;
            scfg_s1_reg <= i_serial_cfg;
            scfg_s2_reg <= scfg_s1_reg;
        end
    end

    // ==========================================================
    // Mode decode
    wire alo_pkg::alo_cfg_t cfg_sel;
    alo_pkg::alo_cfg_t act_cfg_reg;
    wire alo_pkg::alo_cfg_t cur_cfg;
    logic phase_reg, samp_ev_reg, primed_reg, wrap_reg;
    logic [AW-1:0] wr_ptr_reg;
    wire logic edge_ev, frame_start, load, two_lane, is16, word, half, sdr_cur;
    wire logic [4:0] len_cur;

    assign cfg_sel = sel_s2_reg ? scfg_s2_reg : pcfg_s2_reg;
    assign edge_ev = sclk_s2_reg & ~sclk_s3_reg;
    assign frame_start = samp_ev_reg & ~phase_reg;
    assign cur_cfg = frame_start ? cfg_sel : act_cfg_reg;
    assign two_lane = (cur_cfg.lane_mode == alo_pkg::ALO_TWO_16X) || (cur_cfg.lane_mode == alo_pkg::ALO_TWO_14X);
    assign is16 = two_lane ? (cur_cfg.lane_mode == alo_pkg::ALO_TWO_16X) : cur_cfg.one_lane_16x;
    assign word = two_lane & (cur_cfg.split == alo_pkg::ALO_SPLIT_WORD);
    assign half = two_lane & (word | ((cur_cfg.lane_mode == alo_pkg::ALO_TWO_14X) & ~cur_cfg.bit_clk_sdr));
    assign sdr_cur = two_lane & cur_cfg.bit_clk_sdr;
    assign load = samp_ev_reg & (~word | phase_reg);
    assign len_cur = (!two_lane || word) ? (is16 ? `ALO_LEN_ONE_16 : `ALO_LEN_ONE_14)
                                         : (is16 ? `ALO_LEN_TWO_16 : `ALO_LEN_TWO_14);

    // ==========================================================
    // Conversion latency memory
    alo_mem_if #(.W(MW), .AW(AW)) mem_bus ();

    assign mem_bus.en = edge_ev;
    assign mem_bus.addr = wr_ptr_reg;
    assign mem_bus.wdata = din_s2_reg;

    alo_delay_mem #(.W(MW), .DEPTH(LAT), .AW(AW)) u_mem (
        .i_mclk(i_mclk),
        .m(mem_bus)
    );

    // Read data is forced to zero until the memory has been filled once
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            wrap_reg <= 1'b0;
            primed_reg <= 1'b0;
            samp_ev_reg <= 1'b0;
        end else begin
            samp_ev_reg <= edge_ev;
            if (edge_ev) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(LAT - 1)) ? '0 : wr_ptr_reg + AW'(1);
                // Primed one event after the wrap, so an unwritten slot is never sent
                wrap_reg <= wrap_reg | (wr_ptr_reg == AW'(LAT - 1));
                primed_reg <= wrap_reg;
            end
        end
    end

    // ==========================================================
    // Per-channel formatting and lane shifters
    logic [13:0] code_w [CH];
    logic [15:0] sh0_reg [CH];
    logic [15:0] sh1_reg [CH];
    wire logic adv;

    for (genvar c = 0; c < CH; c++) begin : g_ch
        wire logic [15:0] rd;
        wire logic [15:0] w16;
        wire logic [15:0] v0;
        wire logic [15:0] v1;
        logic [13:0] held_reg;

        assign din_raw[c * 16 +: 16] = {i_ovr_pos[c], i_ovr_neg[c], i_ch_data[c]};
        assign rd = primed_reg ? mem_bus.rdata[c * 16 +: 16] : 16'h0000;
        assign code_w[c] = rd[15] ? (cur_cfg.output_format_select ? `ALO_POS_OB : `ALO_POS_TC)
                         : rd[14] ? (cur_cfg.output_format_select ? `ALO_NEG_OB : `ALO_NEG_TC)
                         : (cur_cfg.output_format_select ? {~rd[13], rd[12:0]} : rd[13:0]);
        assign w16 = {2'b00, code_w[c]};
        assign v0 = word ? {2'b00, held_reg}
                  : !two_lane ? w16
                  : (cur_cfg.split == alo_pkg::ALO_SPLIT_BIT) ? {8'h00, evens(w16)}
                  : {8'h00, w16[7:0]};
        assign v1 = word ? w16
                  : !two_lane ? 16'h0000
                  : (cur_cfg.split == alo_pkg::ALO_SPLIT_BIT) ? {8'h00, odds(w16)}
                  : is16 ? {8'h00, w16[15:8]} : {9'h000, w16[13:7]};

        always_ff @(posedge i_mclk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                held_reg <= '0;
                sh0_reg[c] <= '0;
                sh1_reg[c] <= '0;
            end else if (load) begin
                held_reg <= code_w[c];
                sh0_reg[c] <= place(v0, len_cur, cur_cfg.lsb_first);
                sh1_reg[c] <= place(v1, len_cur, cur_cfg.lsb_first);
            end else begin
                if (samp_ev_reg) begin
                    held_reg <= code_w[c];
                end
                if (adv) begin
                    sh0_reg[c] <= {sh0_reg[c][14:0], 1'b0};
                    sh1_reg[c] <= {sh1_reg[c][14:0], 1'b0};
                end
            end
        end
    end

    // ==========================================================
    // Bit clock divider, bit counter and frame clock
    logic [DVW-1:0] div_reg;
    logic [4:0] cnt_reg, len_reg;
    logic sdr_reg, half_reg, bclk_reg, fclk_reg;
    wire logic tick;
    wire logic [4:0] fall_at;

    assign tick = (div_reg == DVW'(BIT_DIV - 1));
    assign adv = tick & (cnt_reg != 5'd0) & (~sdr_reg | bclk_reg);
    assign fall_at = len_reg - (len_reg >> 1) + 5'd1;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_reg <= 1'b0;
            act_cfg_reg <= '0;
        end else if (samp_ev_reg) begin
            phase_reg <= frame_start & half;
            if (frame_start) begin
                act_cfg_reg <= cfg_sel;
            end
        end
    end

    // Divider restarts on each load so the bit clock stays locked to the sample clock
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_reg <= '0;
            bclk_reg <= 1'b0;
        end else if (load) begin
            div_reg <= '0;
            bclk_reg <= 1'b0;
        end else begin
            div_reg <= tick ? '0 : div_reg + DVW'(1);
            bclk_reg <= bclk_reg ^ tick;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= '0;
            len_reg <= `ALO_LEN_ONE_14;
            sdr_reg <= 1'b0;
            half_reg <= 1'b0;
        end else if (load) begin
            cnt_reg <= len_cur;
            len_reg <= len_cur;
            sdr_reg <= sdr_cur;
            half_reg <= half;
        end else if (adv) begin
            cnt_reg <= cnt_reg - 5'd1;
        end
    end

    // Full rate: high for first half of the word; half rate: high for one sample period
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fclk_reg <= 1'b0;
        end else if (samp_ev_reg) begin
            fclk_reg <= half ? (word ? phase_reg : ~phase_reg) : 1'b1;
        end else if (adv && !half_reg && cnt_reg == fall_at) begin
            fclk_reg <= 1'b0;
        end
    end

    // Drive current and termination settings go to the pad ring
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lane_drive_current_select <= `ALO_CUR_3P5MA;
            o_lane_drive_current_doubling <= 1'b0;
            o_term_clk_sel <= `ALO_TERM_RESET;
            o_term_data_sel <= `ALO_TERM_RESET;
        end else begin
            o_lane_drive_current_select <= cfg_sel.lane_drive_current_select;
            o_lane_drive_current_doubling <= cfg_sel.lane_drive_current_doubling;
            o_term_clk_sel <= cfg_sel.term_clk;
            o_term_data_sel <= cfg_sel.term_data;
        end
    end

    assign o_bit_clk = bclk_reg;
    assign o_frame_clk = fclk_reg;
    assign o_ch_a_lane0 = sh0_reg[0][15];
    assign o_ch_a_lane1 = sh1_reg[0][15];
    assign o_ch_b_lane0 = sh0_reg[1][15];
    assign o_ch_b_lane1 = sh1_reg[1][15];
    assign o_ch_c_lane0 = sh0_reg[2][15];
    assign o_ch_c_lane1 = sh1_reg[2][15];
    assign o_ch_d_lane0 = sh0_reg[3][15];
    assign o_ch_d_lane1 = sh1_reg[3][15];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_cfg_frame_edge: assert property (!$stable(act_cfg_reg) |-> $past(frame_start))
        else $error("active settings changed off a frame boundary");
    a_len_two_16x: assert property (load && two_lane && !word && is16 |=> len_reg == 5'd8)
        else $error("two-lane 16x word length not eight");
    a_len_two_14x: assert property (load && two_lane && !word && !is16 |=> len_reg == 5'd7)
        else $error("two-lane 14x word length not seven");
    a_clamp_pos: assert property (primed_reg && mem_bus.rdata[15]
        |-> code_w[0] == (cur_cfg.output_format_select ? 14'h3FFF : 14'h1FFF))
        else $error("positive overdrive code wrong");
    a_clamp_neg: assert property (primed_reg && !mem_bus.rdata[15] && mem_bus.rdata[14]
        |-> code_w[0] == (cur_cfg.output_format_select ? 14'h0000 : 14'h2000))
        else $error("negative overdrive code wrong");
    a_pad_zero: assert property (load && is16 && two_lane && cur_cfg.split == alo_pkg::ALO_SPLIT_BYTE
        && !cur_cfg.lsb_first |=> o_ch_a_lane1 == 1'b0 ##0 sh1_reg[0][14] == 1'b0)
        else $error("16x padding bits not zero");
    a_sdr_falling: assert property (adv && sdr_reg |-> bclk_reg ##1 !bclk_reg)
        else $error("SDR data moved off the falling bit clock");
    a_word_frame: assert property (load && word |=> o_frame_clk)
        else $error("frame clock not high at word start");
    a_lat_wrap: assert property (edge_ev && wr_ptr_reg == AW'(LAT - 1) |=> wr_ptr_reg == '0)
        else $error("latency pointer did not wrap");
    a_msb_first: assert property (load && !two_lane && !cur_cfg.lsb_first
        |=> o_ch_a_lane0 == ($past(is16) ? 1'b0 : $past(code_w[0][13])))
        else $error("one-lane word did not start with the MSB");

    c_word_load: cover property (load && word);
    c_half_14x: cover property (frame_start && half && !word);
    c_sdr_shift: cover property (adv && sdr_reg);
    c_overdrive: cover property (primed_reg && mem_bus.rdata[15]);
endmodule
`default_nettype wire

// *** alo_defs.svh ***
// Constants for the quad-channel serial lane output block
// Contract
// - Three lane modes: 1-lane, 2-lane 16x/14x
// - One lane: bits change on both edges
// - One lane: word starts at frame rise
// - Two-lane 16x pads two zero MSBs
// - Two-lane 16x: eight bits per lane
// - Two-lane 16x: DDR default, SDR optional
// - Two-lane 14x frame: full SDR, half DDR
// - Two-lane 14x: seven bits per lane
// - Byte-wise: lane0 low byte (seven bits at 14x), lane1 upper
// - Bit-wise: lane0 even bits, lane1 odd
// - Word-wise: samples alternate lane0, lane1
// - Word-wise frame half rate, rises at word
// - MSB first after reset, LSB optional
// - LSB first reverses order per lane
// - Two's complement default, offset binary optional
// - Positive overdrive clamps to full scale
// - Negative overdrive clamps to negative scale
// - Drive current select, 3.5 mA default
// - Doubling control doubles drive current
// - Five termination bits, clock and data
// - Options from parallel pins or serial
// - Twelve sample clock conversion latency
`ifndef ALO_DEFS_SVH
`define ALO_DEFS_SVH

`define ALO_LAT_SAMPLES 12
`define ALO_BIT_DIV 1
`define ALO_LEN_ONE_14 5'h0E
`define ALO_LEN_ONE_16 5'h10
`define ALO_LEN_TWO_14 5'h07
`define ALO_LEN_TWO_16 5'h08
`define ALO_POS_OB 14'h3FFF
`define ALO_POS_TC 14'h1FFF
`define ALO_NEG_OB 14'h0000
`define ALO_NEG_TC 14'h2000
`define ALO_CUR_3P5MA 2'h0
`define ALO_CUR_2P5MA 2'h1
`define ALO_CUR_3P0MA 2'h2
`define ALO_CUR_4P5MA 2'h3
`define ALO_TERM_RESET 5'h00

`endif

// *** alo_pkg.sv ***
// Types shared by the serial lane output block
`default_nettype none
package alo_pkg;
    typedef enum logic [1:0] {ALO_ONE_LANE, ALO_TWO_16X, ALO_TWO_14X} alo_lane_mode_t;
    typedef enum logic [1:0] {ALO_SPLIT_BYTE, ALO_SPLIT_BIT, ALO_SPLIT_WORD} alo_split_t;
    typedef struct packed {
        alo_lane_mode_t lane_mode;
        logic one_lane_16x;
        logic bit_clk_sdr;
        alo_split_t split;
        logic lsb_first;
        logic output_format_select;
        logic [1:0] lane_drive_current_select;
        logic lane_drive_current_doubling;
        logic [4:0] term_clk;
        logic [4:0] term_data;
    } alo_cfg_t;
endpackage
`default_nettype wire

// *** alo_mem_if.sv ***
// Carrier between the serializer and its sample delay memory
`default_nettype none
interface alo_mem_if #(parameter int W = 64, parameter int AW = 4);
    logic en;
    logic [AW-1:0] addr;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    modport master (output en, output addr, output wdata, input rdata);
    modport mem (input en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** alo_delay_mem.sv ***
// Sample delay memory with registered read, read-before-write
`default_nettype none
module alo_delay_mem #(
    parameter int W = 64,
    parameter int DEPTH = 12,
    parameter int AW = 4
) (
    input wire logic i_mclk,
    alo_mem_if.mem m
);
    logic [W-1:0] mem_q [DEPTH];

    // Same-address access returns the word written DEPTH events ago
    always_ff @(posedge i_mclk) begin
        if (m.en) begin
            m.rdata <= mem_q[m.addr];
            mem_q[m.addr] <= m.wdata;
        end
    end
endmodule
`default_nettype wire

// *** alo_rx_model.sv ***
// Receiving deserializer model for the serial lane output block
`default_nettype none
module alo_rx_model (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_bit_clk,
    input wire logic i_frame_clk,
    input wire logic [7:0] i_lanes,
    input wire logic [4:0] i_nbits,
    input wire logic i_sdr,
    input wire logic [15:0] i_tag,
    output logic o_done,
    output logic [15:0] o_tag,
    output logic [7:0][15:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bclk_reg;
    logic frame_reg;
    logic busy_reg;
    logic [4:0] cnt_reg;
    logic [7:0][15:0] acc_reg;
    // ==========================================
    // Word capture
    // Only the word opened by a frame rise is taken; a second word inside a half-rate frame is not
    wire logic start = i_frame_clk & ~frame_reg;
    wire logic adv = i_sdr ? (bclk_reg & ~i_bit_clk) : (bclk_reg ^ i_bit_clk);
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bclk_reg <= 1'b0;
            frame_reg <= 1'b0;
            busy_reg <= 1'b0;
            cnt_reg <= 5'h00;
            acc_reg <= '0;
            o_done <= 1'b0;
            o_tag <= 16'h0000;
            o_word <= '0;
        end else begin
            bclk_reg <= i_bit_clk;
            frame_reg <= i_frame_clk;
            o_done <= 1'b0;
            if (start) begin
                busy_reg <= 1'b1;
                cnt_reg <= 5'h01;
                o_tag <= i_tag;
                for (int i = 0; i < 8; i++) acc_reg[i] <= {15'h0000, i_lanes[i]};
            end else if (busy_reg && cnt_reg == i_nbits) begin
                busy_reg <= 1'b0;
                o_done <= 1'b1;
                o_word <= acc_reg;
            end else if (busy_reg && adv) begin
                cnt_reg <= cnt_reg + 5'h01;
                for (int i = 0; i < 8; i++) acc_reg[i] <= {acc_reg[i][14:0], i_lanes[i]};
            end
        end
    end
endmodule
`default_nettype wire

// *** alo_serial_lane_out_bench.sv ***
// Self-checking bench for the serial lane output block
`default_nettype none
module alo_serial_lane_out_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 2;
    logic i_mclk, i_rst_b, i_sample_clk, i_cfg_from_serial;
    logic [3:0][13:0] i_ch_data;
    logic [3:0] i_ovr_pos, i_ovr_neg;
    alo_pkg::alo_cfg_t i_pin_cfg, i_serial_cfg, cur;
    logic o_bit_clk, o_frame_clk, o_lane_drive_current_doubling;
    logic o_ch_a_lane0, o_ch_a_lane1, o_ch_b_lane0, o_ch_b_lane1;
    logic o_ch_c_lane0, o_ch_c_lane1, o_ch_d_lane0, o_ch_d_lane1;
    logic [1:0] o_lane_drive_current_select;
    logic [4:0] o_term_clk_sel, o_term_data_sel;
    logic rx_done;
    logic [15:0] rx_tag;
    logic [7:0][15:0] rx_word;
    logic [3:0][13:0] hd [0:1023];
    logic [3:0] hp [0:1023];
    logic [3:0] hn [0:1023];
    logic [31:0] rng;
    int err_total, tests_run, k, k_rise, chk_from, cycles, half;
    logic chk_on, fr_prev;
    wire logic two = (cur.lane_mode == alo_pkg::ALO_TWO_16X) || (cur.lane_mode == alo_pkg::ALO_TWO_14X);
    wire logic w16 = two ? (cur.lane_mode == alo_pkg::ALO_TWO_16X) : cur.one_lane_16x;
    wire logic word = two && (cur.split == alo_pkg::ALO_SPLIT_WORD);
    wire logic sdr = two && cur.bit_clk_sdr;
    wire logic halfr = word || (cur.lane_mode == alo_pkg::ALO_TWO_14X && !cur.bit_clk_sdr);
    wire logic [4:0] nb = (!two || word) ? (w16 ? 5'h10 : 5'h0E) : (w16 ? 5'h08 : 5'h07);

    alo_serial_lane_out #(.BIT_DIV(1), .LAT(LAT)) u_dut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sample_clk(i_sample_clk), .i_ch_data(i_ch_data),
        .i_ovr_pos(i_ovr_pos), .i_ovr_neg(i_ovr_neg), .i_pin_cfg(i_pin_cfg), .i_serial_cfg(i_serial_cfg),
        .i_cfg_from_serial(i_cfg_from_serial), .o_bit_clk(o_bit_clk), .o_frame_clk(o_frame_clk),
        .o_ch_a_lane0(o_ch_a_lane0), .o_ch_a_lane1(o_ch_a_lane1), .o_ch_b_lane0(o_ch_b_lane0),
        .o_ch_b_lane1(o_ch_b_lane1), .o_ch_c_lane0(o_ch_c_lane0), .o_ch_c_lane1(o_ch_c_lane1),
        .o_ch_d_lane0(o_ch_d_lane0), .o_ch_d_lane1(o_ch_d_lane1),
        .o_lane_drive_current_select(o_lane_drive_current_select),
        .o_lane_drive_current_doubling(o_lane_drive_current_doubling),
        .o_term_clk_sel(o_term_clk_sel), .o_term_data_sel(o_term_data_sel));

    alo_rx_model u_rx (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bit_clk(o_bit_clk), .i_frame_clk(o_frame_clk),
        .i_lanes({o_ch_d_lane1, o_ch_d_lane0, o_ch_c_lane1, o_ch_c_lane0,
                  o_ch_b_lane1, o_ch_b_lane0, o_ch_a_lane1, o_ch_a_lane0}),
        .i_nbits(nb), .i_sdr(sdr), .i_tag(k[15:0]), .o_done(rx_done), .o_tag(rx_tag), .o_word(rx_word));

    // ==========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [13:0] code_of(input int idx, input int ch);
        logic [13:0] d;
        d = (idx < 1) ? 14'h0000 : hd[idx][ch];
        if (idx >= 1 && hp[idx][ch]) d = cur.output_format_select ? 14'h3FFF : 14'h1FFF;
        else if (idx >= 1 && hn[idx][ch]) d = cur.output_format_select ? 14'h0000 : 14'h2000;
        else if (cur.output_format_select) d = d ^ 14'h2000;
        return d;
    endfunction

    function automatic logic [15:0] lane_exp(input logic [13:0] c, input logic [13:0] c2, input int ln);
        logic [15:0] w, r, q;
        int n;
        n = int'(nb);
        w = {2'b00, (word && ln == 1) ? c2 : c};
        r = w;
        if (two && !word && cur.split == alo_pkg::ALO_SPLIT_BYTE) r = (ln == 1) ? (w >> n) : w;
        if (two && !word && cur.split == alo_pkg::ALO_SPLIT_BIT)
            for (int i = 0; i < 8; i++) r[i] = w[2 * i + ln];
        for (int i = 0; i < 16; i++) q[i] = (i < n) ? (cur.lsb_first ? r[n - 1 - i] : r[i]) : 1'b0;
        return q;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic set_cfg(input int m, input int p);
        alo_pkg::alo_cfg_t c;
        logic [2:0] b;
        b = m[2:0];
        c = '0;
        c.lane_mode = (m < 2) ? alo_pkg::ALO_ONE_LANE : ((m < 5) ? alo_pkg::ALO_TWO_16X : alo_pkg::ALO_TWO_14X);
        c.one_lane_16x = (m == 1);
        c.bit_clk_sdr = (m == 3) || (m == 5);
        c.split = (m == 2 || m == 5) ? alo_pkg::ALO_SPLIT_BYTE
                : ((m == 3 || m == 6) ? alo_pkg::ALO_SPLIT_BIT : alo_pkg::ALO_SPLIT_WORD);
        c.lsb_first = (^b) ^ p[0];
        c.output_format_select = b[1] ^ p[0];
        c.lane_drive_current_select = b[1:0];
        c.lane_drive_current_doubling = b[2] ^ p[0];
        rng = xs(rng);
        c.term_clk = rng[4:0];
        c.term_data = rng[12:8];
        chk_on = 1'b0;
        // Long words need a slower sample rate, as a real host would pick
        half = ((m < 2) || c.bit_clk_sdr) ? 160 : 80;
        repeat (2) @(posedge i_sample_clk);
        @(posedge i_mclk);
        i_cfg_from_serial <= b[0] ^ p[0];
        i_serial_cfg <= (b[0] ^ p[0]) ? c : ~c;
        i_pin_cfg <= (b[0] ^ p[0]) ? ~c : c;
        cur = c;
        chk_from = k + LAT + 3;
        chk_on = 1'b1;
        repeat (8) @(posedge i_mclk);
        chk({14'h0000, o_lane_drive_current_select}, {14'h0000, c.lane_drive_current_select});
        chk({15'h0000, o_lane_drive_current_doubling}, {15'h0000, c.lane_drive_current_doubling});
        chk({6'h00, o_term_clk_sel, o_term_data_sel}, {6'h00, c.term_clk, c.term_data});
        repeat (12) @(posedge i_sample_clk);
    endtask

    // ==========================================
    // Clocks and sample stream
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial begin
        logic [3:0][13:0] nd;
        logic [3:0] np, nn;
        i_sample_clk = 1'b0;
        i_ch_data = '0;
        i_ovr_pos = '0;
        i_ovr_neg = '0;
        k = 0;
        half = 80;
        rng = 32'h869E;
        wait (i_rst_b === 1'b1);
        // Edges move on mclk rises by NBA, so the synchroniser never races the pin
        forever begin
            repeat (half / 10) @(posedge i_mclk);
            i_sample_clk <= 1'b1;
            k = k + 1;
            hd[k] = i_ch_data;
            hp[k] = i_ovr_pos;
            hn[k] = i_ovr_neg;
            repeat (half / 10) @(posedge i_mclk);
            i_sample_clk <= 1'b0;
            for (int ch = 0; ch < 4; ch++) begin
                rng = xs(rng);
                nd[ch] = (k % 6 == 0) ? ((ch % 2 == 1) ? 14'h2000 : 14'h1FFF) : rng[13:0];
                np[ch] = (rng[18:16] == 3'h0);
                nn[ch] = (rng[22:20] == 3'h0);
            end
            i_ch_data <= nd;
            i_ovr_pos <= np;
            i_ovr_neg <= nn;
        end
    end

    // ==========================================
    // Frame and word checks
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
        fr_prev <= o_frame_clk;
        if (o_frame_clk && !fr_prev) begin
            if (chk_on && k_rise >= chk_from) chk(16'(k - k_rise), halfr ? 16'h0002 : 16'h0001);
            k_rise = k;
        end
        if (rx_done && chk_on && int'(rx_tag) >= chk_from)
            for (int ch = 0; ch < 4; ch++)
                for (int ln = 0; ln < (two ? 2 : 1); ln++)
                    chk(rx_word[2 * ch + ln], lane_exp(code_of(int'(rx_tag) - LAT - (word ? 1 : 0), ch),
                        code_of(int'(rx_tag) - LAT, ch), ln));
    end

    initial begin
        i_rst_b = 1'b0;
        i_pin_cfg = '0;
        i_serial_cfg = '0;
        i_cfg_from_serial = 1'b0;
        cur = '0;
        chk_on = 1'b0;
        fr_prev = 1'b0;
        err_total = 0;
        tests_run = 0;
        chk_from = 0;
        k_rise = 0;
        repeat (3) @(posedge i_mclk);
        chk({o_bit_clk, o_frame_clk, o_ch_a_lane0, o_ch_a_lane1, o_ch_b_lane0, o_ch_b_lane1, o_ch_c_lane0,
             o_ch_c_lane1, o_ch_d_lane0, o_ch_d_lane1, o_lane_drive_current_doubling,
             o_lane_drive_current_select, 3'h0}, 16'h0000);
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_mclk);
        chk({14'h0000, o_lane_drive_current_select}, 16'h0000);
        for (int p = 0; p < 2; p++)
            for (int m = 0; m < 8; m++) set_cfg(m, p);
        final_report();
    end
endmodule
`default_nettype wire
